// >>> rtl/chan_exec_pkg.sv
// Purpose: Shared constants for the channel instruction execution unit
// Assumes: 100 MHz core clock
// Notes:   Clock figures are in processor clock periods
package chan_exec_pkg;
    // =========================================================
    // Operation select codes
    typedef enum logic [2:0] {
        OP_LOAD_PTR_IMM  = 3'h0,
        OP_PTR_FROM_MEM  = 3'h1,
        OP_PTR_TO_MEM    = 3'h2,
        OP_OR_BYTE_IMM   = 3'h3,
        OP_TEST_SET      = 3'h4,
        OP_TRANSFER_MODE_ENTRY_ENTRY    = 3'h5,
        OP_OTHER         = 3'h6
    } op_sel_e;

    // =========================================================
    // Clock period counts
    localparam logic [4:0] CLK_LPI_EVEN  = 5'h0C; // 12
    localparam logic [4:0] CLK_LPI_ODD   = 5'h10; // 16
    localparam logic [4:0] CLK_MPL_EVEN  = 5'h13; // 19
    localparam logic [4:0] CLK_MPL_ODD   = 5'h1B; // 27
    localparam logic [4:0] CLK_MPS_EVEN  = 5'h10; // 16
    localparam logic [4:0] CLK_MPS_ODD   = 5'h16; // 22
    localparam logic [4:0] CLK_TS_NZ     = 5'h0E; // 14
    localparam logic [4:0] CLK_TS_ZERO   = 5'h10; // 16
    localparam logic [4:0] CLK_TRANSFER_MODE_ENTRY      = 5'h04;
    localparam logic [4:0] CLK_OR_BYTE_IMMEDIATE      = 5'h03;
    localparam logic [4:0] CLK_OTHER     = 5'h04;

    // =========================================================
    // Instruction lengths in bytes
    localparam logic [2:0] LEN_LPI       = 3'h6;
    localparam logic [2:0] LEN_TRANSFER_MODE_ENTRY      = 3'h2;
    localparam logic [2:0] LEN_OR_BYTE_IMMEDIATE      = 3'h3;
    localparam logic [2:0] LEN_MOVE_POINTER      = 3'h2;
    localparam logic [2:0] LEN_TS        = 3'h4;
    localparam logic [2:0] LEN_OTHER     = 3'h2;

    // =========================================================
    // Register file shape
    localparam int         PTR_W         = 20;
    localparam int         NUM_PTR       = 4;
    localparam int         NUM_GPR       = 8;
    localparam logic [15:0] GPR_RESET    = 16'h0000;
    localparam logic [19:0] PTR_RESET    = 20'h00000;
endpackage

// >>> rtl/cycle_timer.sv
// Purpose: Counts down one instruction's clock periods
// Assumes: Load value of at least one
// Notes:   o_last is high in the final period
`timescale 1ns/1ps
module cycle_timer
    import chan_exec_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_load,
    input  wire logic [4:0] i_count,
    output logic            o_busy,
    output logic            o_last
);
    logic [4:0] remain;
    logic [4:0] next_remain;

    // =========================================================
    // Countdown
    always_comb begin
        next_remain = remain;
        if (i_load) begin
            next_remain = i_count;
        end else if (remain != 5'h00) begin
            next_remain = remain - 5'h01;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            remain <= 5'h00;
        end else begin
            remain <= next_remain;
        end
    end

    assign o_busy = (remain != 5'h00);
    assign o_last = (remain == 5'h01);
endmodule

// >>> rtl/chan_exec_unit.sv
// Purpose: Executes pointer, OR-byte, test-set and transfer-entry ops
// Assumes: Memory bus answers reads and writes in one cycle per access
// Notes:   Every op holds o_busy for exactly its clock period count
`timescale 1ns/1ps
module chan_exec_unit
    import chan_exec_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_start,
    input  wire logic [2:0]  i_op,
    input  wire logic [19:0] i_instr_addr,
    input  wire logic [19:0] i_operand_addr,
    input  wire logic [1:0]  i_ptr_sel,
    input  wire logic [2:0]  i_reg_sel,
    input  wire logic [31:0] i_immediate,
    input  wire logic [23:0] i_mem_rdata,
    output logic             o_busy,
    output logic             o_done,
    output logic [2:0]       o_length,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic             o_mem_lock,
    output logic [19:0]      o_mem_addr,
    output logic [23:0]      o_mem_wdata,
    output logic             o_dma_mode,
    output logic             o_test_zero,
    output logic [19:0]      o_ptr_value,
    output logic [15:0]      o_reg_value
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} exec_state_e;

    exec_state_e        state;
    exec_state_e        next_state;
    op_sel_e            op;
    op_sel_e            next_op;
    logic [19:0]        ptr_file [NUM_PTR];
    logic [19:0]        next_ptr_file [NUM_PTR];
    logic [15:0]        gpr_file [NUM_GPR];
    logic [15:0]        next_gpr_file [NUM_GPR];
    logic [1:0]         ptr_idx;
    logic [1:0]         next_ptr_idx;
    logic [2:0]         reg_idx;
    logic [2:0]         next_reg_idx;
    logic [19:0]        opnd;
    logic [19:0]        next_opnd;
    logic [7:0]         set_val;
    logic [7:0]         next_set_val;
    logic [4:0]         elapsed;
    logic [4:0]         next_elapsed;
    logic               transfer_mode_entry_armed;
    logic               next_transfer_mode_entry_armed;
    logic               next_busy;
    logic               next_done;
    logic [2:0]         next_length;
    logic               next_mem_rd;
    logic               next_mem_wr;
    logic               next_mem_lock;
    logic [19:0]        next_mem_addr;
    logic [23:0]        next_mem_wdata;
    logic               next_dma_mode;
    logic               next_test_zero;
    logic               load_timer;
    logic [4:0]         load_count;
    logic               timer_last;

    // Pick even or odd figure from an address
    function automatic logic [4:0] by_parity(input logic [19:0] addr,
                                             input logic [4:0] even_c,
                                             input logic [4:0] odd_c);
        by_parity = addr[0] ? odd_c : even_c;
    endfunction

    // =========================================================
    // Timer
    cycle_timer cycle_timer_inst (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_load     (load_timer),
        .i_count    (load_count),
        .o_busy     (),
        .o_last     (timer_last)
    );

    // =========================================================
    // Sequencing, bus and register updates
    always_comb begin
        next_state      = state;
        next_op         = op;
        next_ptr_file   = ptr_file;
        next_gpr_file   = gpr_file;
        next_ptr_idx    = ptr_idx;
        next_reg_idx    = reg_idx;
        next_opnd       = opnd;
        next_set_val    = set_val;
        next_elapsed    = elapsed;
        next_transfer_mode_entry_armed = transfer_mode_entry_armed;
        next_busy       = o_busy;
        next_done       = 1'b0;
        next_length     = o_length;
        next_mem_rd     = 1'b0;
        next_mem_wr     = 1'b0;
        next_mem_lock   = o_mem_lock;
        next_mem_addr   = o_mem_addr;
        next_mem_wdata  = o_mem_wdata;
        next_dma_mode   = o_dma_mode;
        next_test_zero  = o_test_zero;
        load_timer      = 1'b0;
        load_count      = CLK_OTHER;
        unique case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_state   = ST_RUN;
                    next_op      = op_sel_e'(i_op);
                    next_ptr_idx = i_ptr_sel;
                    next_reg_idx = i_reg_sel;
                    next_opnd    = i_operand_addr;
                    next_set_val = i_immediate[7:0];
                    next_elapsed = 5'h01;
                    next_busy    = 1'b1;
                    load_timer   = 1'b1;
                    case (i_op)
                        OP_LOAD_PTR_IMM: begin
                            load_count  = by_parity(i_instr_addr,
                                CLK_LPI_EVEN, CLK_LPI_ODD);
                            next_length = LEN_LPI;
                        end
                        OP_PTR_FROM_MEM: begin
                            load_count  = by_parity(i_operand_addr,
                                CLK_MPL_EVEN, CLK_MPL_ODD);
                            next_length = LEN_MOVE_POINTER;
                        end
                        OP_PTR_TO_MEM: begin
                            load_count  = by_parity(i_operand_addr,
                                CLK_MPS_EVEN, CLK_MPS_ODD);
                            next_length = LEN_MOVE_POINTER;
                        end
                        OP_OR_BYTE_IMM: begin
                            load_count  = CLK_OR_BYTE_IMMEDIATE;
                            next_length = LEN_OR_BYTE_IMMEDIATE;
                        end
                        OP_TEST_SET: begin
                            // Lock raised in the same cycle as the read goes out
                            load_count    = CLK_TS_ZERO;
                            next_length   = LEN_TS;
                            next_mem_lock = 1'b1;
                            next_mem_rd   = 1'b1;
                            next_mem_addr = i_operand_addr;
                        end
                        OP_TRANSFER_MODE_ENTRY_ENTRY: begin
                            load_count  = CLK_TRANSFER_MODE_ENTRY;
                            next_length = LEN_TRANSFER_MODE_ENTRY;
                        end
                        default: begin
                            load_count  = CLK_OTHER;
                            next_length = LEN_OTHER;
                        end
                    endcase
                end
            end
            ST_RUN: begin
                next_elapsed = elapsed + 5'h01;
                // Test byte sampled one cycle after the read
                if (op == OP_TEST_SET && elapsed == 5'h02) begin
                    next_test_zero = (i_mem_rdata[7:0] == 8'h00);
                    if (i_mem_rdata[7:0] != 8'h00) begin
                        // Nonzero: skip write, finish early
                        load_timer = 1'b1;
                        load_count = CLK_TS_NZ - 5'h02;
                    end else begin
                        next_mem_wr    = 1'b1;
                        next_mem_wdata = {16'h0000, set_val};
                    end
                end
                if (op == OP_PTR_FROM_MEM && elapsed == 5'h01) begin
                    next_mem_rd   = 1'b1;
                    next_mem_addr = opnd;
                end
                // Read data stands the cycle after the strobe
                if (op == OP_PTR_FROM_MEM && elapsed == 5'h03) begin
                    next_ptr_file[ptr_idx] = i_mem_rdata[19:0];
                end
                if (op == OP_PTR_TO_MEM && elapsed == 5'h01) begin
                    next_mem_wr    = 1'b1;
                    next_mem_addr  = opnd;
                    next_mem_wdata = {4'h0, ptr_file[ptr_idx]};
                end
                if (timer_last) begin
                    next_state    = ST_IDLE;
                    next_busy     = 1'b0;
                    next_done     = 1'b1;
                    next_mem_lock = 1'b0;
                    unique case (op)
                        OP_LOAD_PTR_IMM: begin
                            next_ptr_file[ptr_idx] =
                                i_immediate[19:0];
                        end
                        OP_OR_BYTE_IMM: begin
                            next_gpr_file[reg_idx] = gpr_file[reg_idx]
                                | {8'h00, i_immediate[7:0]};
                        end
                        default: begin
                        end
                    endcase
                    // DMA starts after the following op completes
                    if (op == OP_TRANSFER_MODE_ENTRY_ENTRY) begin
                        next_transfer_mode_entry_armed = 1'b1;
                    end else if (transfer_mode_entry_armed) begin
                        next_transfer_mode_entry_armed = 1'b0;
                        next_dma_mode   = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // State registers
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state       <= ST_IDLE;
            op          <= OP_OTHER;
            for (int i = 0; i < NUM_PTR; i++) begin
                ptr_file[i] <= PTR_RESET;
            end
            for (int i = 0; i < NUM_GPR; i++) begin
                gpr_file[i] <= GPR_RESET;
            end
            ptr_idx     <= 2'h0;
            reg_idx     <= 3'h0;
            opnd        <= 20'h00000;
            set_val     <= 8'h00;
            elapsed     <= 5'h00;
            transfer_mode_entry_armed  <= 1'b0;
            o_busy      <= 1'b0;
            o_done      <= 1'b0;
            o_length    <= 3'h0;
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_lock  <= 1'b0;
            o_mem_addr  <= 20'h00000;
            o_mem_wdata <= 24'h000000;
            o_dma_mode  <= 1'b0;
            o_test_zero <= 1'b0;
            o_ptr_value <= PTR_RESET;
            o_reg_value <= GPR_RESET;
        end else begin
            state       <= next_state;
            op          <= next_op;
            ptr_file    <= next_ptr_file;
            gpr_file    <= next_gpr_file;
            ptr_idx     <= next_ptr_idx;
            reg_idx     <= next_reg_idx;
            opnd        <= next_opnd;
            set_val     <= next_set_val;
            elapsed     <= next_elapsed;
            transfer_mode_entry_armed  <= next_transfer_mode_entry_armed;
            o_busy      <= next_busy;
            o_done      <= next_done;
            o_length    <= next_length;
            o_mem_rd    <= next_mem_rd;
            o_mem_wr    <= next_mem_wr;
            o_mem_lock  <= next_mem_lock;
            o_mem_addr  <= next_mem_addr;
            o_mem_wdata <= next_mem_wdata;
            o_dma_mode  <= next_dma_mode;
            o_test_zero <= next_test_zero;
            o_ptr_value <= next_ptr_file[i_ptr_sel];
            o_reg_value <= next_gpr_file[i_reg_sel];
        end
    end
endmodule

// >>> tb/chan_exec_chk.sv
// Purpose: Concurrent checks on the channel execution unit ports
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to chan_exec_unit at the foot of this file
`timescale 1ns/1ps
module chan_exec_chk
    import chan_exec_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_start,
    input  wire logic [2:0]  i_op,
    input  wire logic [19:0] i_instr_addr,
    input  wire logic [19:0] i_operand_addr,
    input  wire logic        o_busy,
    input  wire logic        o_done,
    input  wire logic [2:0]  o_length,
    input  wire logic        o_mem_wr,
    input  wire logic        o_mem_lock,
    input  wire logic        o_dma_mode,
    input  wire logic        o_test_zero
);
    // ==========================================================
    // Helper state
    logic [2:0] cur_op;
    logic       par;
    logic [5:0] cnt;

    // Latch the op and address parity when taken, count busy periods
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            cur_op <= 3'h7;
            par    <= 1'b0;
            cnt    <= 6'h00;
        end else if (i_start && !o_busy) begin
            cur_op <= i_op;
            par    <= (i_op == OP_LOAD_PTR_IMM) ? i_instr_addr[0]
                                                : i_operand_addr[0];
            cnt    <= 6'h00;
        end else if (o_busy) begin
            cnt    <= cnt + 6'h01;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    // End of an op of the given kind
    sequence s_fin(logic [2:0] op);
        $fell(o_busy) && cur_op == op;
    endsequence

    a_lpi_time: assert property (
        s_fin(OP_LOAD_PTR_IMM) |-> cnt == (par ? 6'h10 : 6'h0C))
        else $error("pointer immediate period count wrong");
    a_move_pointer_load: assert property (
        s_fin(OP_PTR_FROM_MEM) |-> cnt == (par ? 6'h1B : 6'h13))
        else $error("pointer load period count wrong");
    a_move_pointer_store: assert property (
        s_fin(OP_PTR_TO_MEM) |-> cnt == (par ? 6'h16 : 6'h10))
        else $error("pointer store period count wrong");
    a_ts_time: assert property (
        s_fin(OP_TEST_SET) |-> cnt == (o_test_zero ? 6'h10 : 6'h0E))
        else $error("test-set period count wrong");
    a_transfer_mode_entry_time: assert property (
        s_fin(OP_TRANSFER_MODE_ENTRY_ENTRY) |-> cnt == 6'h04)
        else $error("transfer entry period count wrong");
    a_or_byte_immediate_time: assert property (
        s_fin(OP_OR_BYTE_IMM) |-> cnt == 6'h03)
        else $error("OR byte period count wrong");
    a_lock_span: assert property (
        o_busy && cur_op == OP_TEST_SET |-> o_mem_lock)
        else $error("bus lock dropped during test-set");
    a_wr_locked: assert property (
        o_mem_wr && cur_op == OP_TEST_SET |-> o_mem_lock && $past(o_mem_lock))
        else $error("test-set write outside lock");
    a_dma_late: assert property (
        $rose(o_dma_mode) |-> o_done && cur_op != OP_TRANSFER_MODE_ENTRY_ENTRY)
        else $error("transfer mode entered too early");
    a_done_pulse: assert property (
        $fell(o_busy) |-> o_done ##1 !o_done)
        else $error("done pulse wrong");
    a_length_val: assert property (
        $rose(o_busy) |=> o_length == (cur_op == OP_LOAD_PTR_IMM ? 3'h6 :
            cur_op == OP_OR_BYTE_IMM ? 3'h3 :
            cur_op == OP_TEST_SET ? 3'h4 : 3'h2))
        else $error("instruction length wrong");
endmodule

bind chan_exec_unit chan_exec_chk chan_exec_chk_inst (
    .i_core_clk, .i_resetn, .i_start, .i_op, .i_instr_addr,
    .i_operand_addr, .o_busy, .o_done, .o_length, .o_mem_wr,
    .o_mem_lock, .o_dma_mode, .o_test_zero);

// >>> tb/chan_mem_model.sv
// Purpose: Behavioural system memory on the far side of the unit
// Assumes: Read data is returned the cycle after a read strobe
// Notes:   Sixteen words; outside a read the data lines keep toggling
`timescale 1ns/1ps
module chan_mem_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_wr,
    input  wire logic [19:0] i_mem_addr,
    input  wire logic [23:0] i_mem_wdata,
    output logic      [23:0] o_mem_rdata
);
    logic [23:0] mem [0:15];

    // Store writes, answer reads, scramble idle data lines
    initial o_mem_rdata = 24'h5A5A5A;
    always @(posedge i_core_clk) begin
        if (i_mem_wr) begin
            mem[i_mem_addr[3:0]] <= i_mem_wdata;
        end
        if (i_mem_rd) begin
            o_mem_rdata <= mem[i_mem_addr[3:0]];
        end else begin
            o_mem_rdata <= ~o_mem_rdata; // No stale value held
        end
    end
endmodule

// >>> tb/io_channel_instruction_timing_test.sv
// Purpose: Self-checking bench for the channel execution unit
// Assumes: 100 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   Ops run back to back wherever the check allows
`timescale 1ns/1ps
module io_channel_instruction_timing_test;
    import chan_exec_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_start = 1'b0;
    logic [2:0]  i_op = 3'h0;
    logic [19:0] i_instr_addr = 20'h00000;
    logic [19:0] i_operand_addr = 20'h00000;
    logic [1:0]  i_ptr_sel = 2'h2;
    logic [2:0]  i_reg_sel = 3'h3;
    logic [31:0] i_immediate = 32'h00000000;
    logic [23:0] i_mem_rdata;
    logic        o_busy, o_done, o_mem_rd, o_mem_wr, o_mem_lock;
    logic        o_dma_mode, o_test_zero;
    logic [2:0]  o_length;
    logic [19:0] o_mem_addr, o_ptr_value;
    logic [23:0] o_mem_wdata;
    logic [15:0] o_reg_value;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [5:0]  n;

    // ==========================================================
    // Clock, instances, timeout
    initial forever #5 i_core_clk = ~i_core_clk;
    chan_exec_unit chan_exec_unit_inst (.*);
    chan_mem_model chan_mem_model_inst (.i_core_clk, .i_mem_rd(o_mem_rd),
        .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
        .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));
    always @(posedge i_core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Issue one op, count busy periods, end in the done cycle
    task automatic do_op(input logic [2:0] op, input logic [19:0] oa,
            input logic [19:0] ia, input logic [31:0] imm);
        n = 6'h00;
        i_op = op;
        i_operand_addr = oa;
        i_instr_addr = ia;
        i_immediate = imm;
        i_start = 1'b1;
        @(posedge i_core_clk);
        #1;
        i_start = 1'b0;
        while (o_busy === 1'b1 && n < 6'h3F) begin
            n = n + 6'h01;
            @(posedge i_core_clk);
            #1;
        end
        check(o_done, 1'b1);
    endtask

    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_load_ptr();
        do_op(OP_LOAD_PTR_IMM, 20'h00000, 20'h00100, 32'h000ABCDE);
        check(n, 6'h0C);
        check(o_length, 3'h6);
        do_op(OP_LOAD_PTR_IMM, 20'h00000, 20'h00101, 32'h00012345);
        check(n, 6'h10);
        settle();
        check(o_ptr_value, 20'h12345);
    endtask

    task automatic test_move_ptr();
        logic [2:0]  ops [4] = '{3'h2, 3'h2, 3'h1, 3'h1};
        logic [19:0] adr [4] = '{20'h00004, 20'h00005, 20'h00004, 20'h00007};
        logic [5:0]  exp [4] = '{6'h10, 6'h16, 6'h13, 6'h1B};
        chan_mem_model_inst.mem[7] = 24'h054321;
        for (int k = 0; k < 4; k++) begin
            do_op(ops[k], adr[k], 20'h00000, 32'h00000000);
            check(n, exp[k]);
        end
        check(chan_mem_model_inst.mem[4][19:0], 20'h12345);
        settle();
        check(o_ptr_value, 20'h54321);
    endtask

    task automatic test_or_byte();
        do_op(OP_OR_BYTE_IMM, 20'h00000, 20'h00000, 32'h00000011);
        check(n, 6'h03);
        check(o_length, 3'h3);
        do_op(OP_OR_BYTE_IMM, 20'h00000, 20'h00000, 32'h00000080);
        settle();
        check(o_reg_value, 16'h0091);
    endtask

    task automatic test_test_set();
        chan_mem_model_inst.mem[4] = 24'h000000;
        do_op(OP_TEST_SET, 20'h00004, 20'h00000, 32'h000000FF);
        check(n, 6'h10);
        check(o_test_zero, 1'b1);
        check(o_mem_lock, 1'b0);
        check(chan_mem_model_inst.mem[4][7:0], 8'hFF);
        do_op(OP_TEST_SET, 20'h00004, 20'h00000, 32'h00000033);
        check(n, 6'h0E);
        check(o_test_zero, 1'b0);
        check(chan_mem_model_inst.mem[4][7:0], 8'hFF);
    endtask

    task automatic test_transfer_mode_entry();
        do_op(OP_TRANSFER_MODE_ENTRY_ENTRY, 20'h00000, 20'h00000, 32'h00000000);
        check(n, 6'h04);
        check(o_length, 3'h2);
        check(o_dma_mode, 1'b0);
        do_op(OP_OR_BYTE_IMM, 20'h00000, 20'h00000, 32'h00000000);
        check(o_dma_mode, 1'b1);
        do_op(OP_OTHER, 20'h00000, 20'h00000, 32'h00000000);
        check(o_dma_mode, 1'b1);
    endtask

    task automatic summarize();
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge i_core_clk);
        #1;
        i_resetn = 1'b1;
        test_load_ptr();
        test_move_ptr();
        test_or_byte();
        test_test_set();
        test_transfer_mode_entry();
        summarize();
    end
endmodule
